// ---- rtl/clk_status_pkg.sv ----
package clk_status_pkg;

  // number of sticky sources, one bit each in enable and sticky registers
  localparam int NFLAG = 6;

  // register offsets on the serial control port
  localparam logic [6:0] OFF_IRQ_EN = 7'h4c;
  localparam logic [6:0] OFF_STICKY = 7'h50;
  localparam logic [6:0] OFF_LIVE = 7'h51;
  localparam logic [6:0] OFF_CALIB = 7'h53;

  // field positions for enable, sticky and live registers; B_CALIB is in the calibration register
  localparam int B_IN0 = 0;
  localparam int B_IN1 = 1;
  localparam int B_HOLD = 2;
  localparam int B_REF = 3;
  localparam int B_VCXO = 4;
  localparam int B_SYNTH = 5;
  localparam int B_SEL = 6;
  localparam int B_CALIB = 2;

  // reset values
  localparam logic [NFLAG-1:0] IRQ_EN_RST = 6'h00;
  localparam logic [NFLAG-1:0] SEEN_RST = 6'h00;
  localparam logic IRQ_IDLE = 1'b1;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // serial frame: 8 command bits (read flag, 7-bit address), 8 data bits
  localparam logic [4:0] SPI_CMD_LAST = 5'h07;
  localparam logic [4:0] SPI_DATA_FIRST = 5'h09;
  localparam logic [4:0] SPI_FRAME_LAST = 5'h0f;
  localparam logic [4:0] SPI_DONE = 5'h10;

  typedef struct packed {
    logic input_select;
    logic synth_locked;
    logic vcxo_locked;
    logic ref_present;
    logic not_holdover;
    logic [1:0] input_active;
    logic calib_busy;
  } live_t;

  // healthy: both plls locked, reference present, no holdover, inputs up
  localparam live_t LIVE_RST = 8'h7e;

  typedef struct packed {
    logic valid;
    logic [6:0] addr;
    logic [7:0] data;
  } reg_wr_t;

endpackage

// ---- rtl/sticky_bank.sv ----
`timescale 1ns/1ps
module sticky_bank
  import clk_status_pkg::*;
(
  input wire logic clk, // register clock
  input wire logic nrst, // synchronous reset, active low
  input wire logic [NFLAG-1:0] set, // live condition active this cycle
  input wire logic [NFLAG-1:0] clr, // write-one-to-clear strobe
  output logic [NFLAG-1:0] seen // event latched since last clear
);

  genvar i;
  generate
    for (i = 0; i < NFLAG; i++) begin : g_flag
      // set beats clear so an event in the clearing cycle survives
      always_ff @(posedge clk) begin
        if (!nrst) begin
          seen[i] <= SEEN_RST[i];
        end else if (set[i]) begin
          seen[i] <= 1'b1; // [R20]
        end else if (clr[i]) begin
          seen[i] <= 1'b0; // [R5]
        end
      end
    end
  endgenerate

endmodule

// ---- rtl/spi_port.sv ----
`timescale 1ns/1ps
module spi_port
  import clk_status_pkg::*;
(
  input wire logic clk, // register clock
  input wire logic nrst, // synchronous reset, active low
  input wire logic sclk, // serial clock, mode 0
  input wire logic sdi, // serial data in
  input wire logic cs_n, // chip select, active low
  output logic sdo, // serial data out
  output logic sdo_oe, // high while sdo is driven
  output reg_wr_t wr, // one-cycle register write
  output logic [6:0] rd_addr, // address of current frame
  input wire logic [7:0] rd_data // register value at rd_addr
);

  logic sclk_q;
  logic [4:0] cnt;
  logic [7:0] shin;
  logic [7:0] cmd;
  logic [7:0] shout;
  logic load;
  wire rise = sclk & ~sclk_q;
  wire fall = ~sclk & sclk_q;
  wire [7:0] next_shin = {shin[6:0], sdi};
  wire shift_out = fall && cnt >= SPI_DATA_FIRST && cnt <= SPI_FRAME_LAST;

  assign rd_addr = cmd[6:0];
  assign sdo = shout[7];

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk;
    end
  end

  // bits after the sixteenth are ignored; one register per frame
  always_ff @(posedge clk) begin
    if (!nrst || cs_n) begin
      cnt <= 5'h00;
      shin <= 8'h00;
      cmd <= 8'h00;
      load <= 1'b0;
    end else begin
      load <= rise && cnt == SPI_CMD_LAST;
      if (rise && cnt != SPI_DONE) begin
        shin <= next_shin;
        cnt <= cnt + 5'h01;
        if (cnt == SPI_CMD_LAST) begin
          cmd <= next_shin;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wr <= '0;
    end else begin
      wr.valid <= !cs_n && rise && cnt == SPI_FRAME_LAST && !cmd[7];
      wr.addr <= cmd[6:0];
      wr.data <= next_shin;
    end
  end

  // read data is fetched one cycle after the address is complete,
  // so sclk must stay low at least two register clocks
  always_ff @(posedge clk) begin
    if (!nrst || cs_n) begin
      shout <= 8'h00;
      sdo_oe <= 1'b0;
    end else if (load && cmd[7]) begin
      shout <= rd_data;
      sdo_oe <= 1'b1;
    end else if (shift_out) begin
      shout <= {shout[6:0], 1'b0};
    end
  end

endmodule

// ---- rtl/clock_status_interrupt_logic.sv ----
`timescale 1ns/1ps
// Function
// R1: every interrupt enable resets to 0; a disabled flag never pulls irq low
// R2: enabled flag becoming active drives the low-active interrupt output to 0
// R3: synthesizer sticky lock reads 0 after any unlock since clear, else 1
// R4: vcxo sticky lock reads 0 after any unlock since clear, else 1
// R5: writing 1 to a sticky lock flag clears it and its pending interrupt
// R6: per input sticky activity reads 0 after loss of signal; write 1 clears
// R7: sticky reference reads 0 after reference loss, else 1; write 1 clears
// R8: sticky holdover reads 0 after any holdover entry; write 1 clears
// R9: live select bit shows input in use by selection logic, 0 or 1
// R10: live synthesizer lock bit is 0 while unlocked, 1 otherwise, read only
// R11: live vcxo lock bit is 0 while unlocked and feeds its sticky flag
// R12: live input activity bit is 0 under loss of signal, feeds sticky flag
// R13: calibration bit reads 1 while calibrating, 0 once done, read only
// R14: two enable bits gate the two inputs' loss-of-signal flags to irq
// R15: one enable bit, reset off, gates the reference-loss flag to irq
// R16: one enable bit, reset off, gates the holdover flag to irq
// R17: live reference bit is 1 with reference at selected input, else 0
// R18: live holdover bit is 0 in holdover, 1 while locked or locking
// R19: irq stays low while any enabled flag is active, high once none
// R20: a flag latches on even one active cycle; writing 0 does nothing
module clock_status_interrupt_logic
  import clk_status_pkg::*;
(
  input wire logic REF_CLK, // register clock, 40 MHz
  input wire logic NRST, // synchronous reset, active low
  input wire logic SCLK, // serial port clock
  input wire logic SDI, // serial port data in
  input wire logic CS_N, // serial port select, active low
  output logic SDO, // serial port data out
  output logic SDO_OE, // high while SDO is driven
  output logic IRQ_OUT_LOW, // interrupt, active low
  input wire logic LIVE_INPUT_SELECT, // input used by selection logic
  input wire logic LIVE_SYNTH_LOCKED, // synthesizer pll locked
  input wire logic LIVE_VCXO_LOCKED, // vcxo pll locked
  input wire logic LIVE_REF_PRESENT, // reference at selected input
  input wire logic LIVE_NOT_HOLDOVER, // vcxo pll not in holdover
  input wire logic [1:0] LIVE_INPUT_ACTIVE, // per input signal present
  input wire logic SYNTH_CALIB_BUSY // synthesizer calibration running
);

  live_t live;
  logic [NFLAG-1:0] irq_en;
  logic [NFLAG-1:0] seen;
  reg_wr_t wr;
  logic [6:0] rd_addr;

  function automatic logic hit(input logic [6:0] a, input logic [6:0] off);
    hit = (a == off);
  endfunction

  // live conditions are registered once so that the sticky latches and
  // the read path see one consistent sample
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      live <= LIVE_RST;
    end else begin
      live.input_select <= LIVE_INPUT_SELECT; // [R9]
      live.synth_locked <= LIVE_SYNTH_LOCKED; // [R10]
      live.vcxo_locked <= LIVE_VCXO_LOCKED; // [R11]
      live.ref_present <= LIVE_REF_PRESENT; // [R17]
      live.not_holdover <= LIVE_NOT_HOLDOVER; // [R18]
      live.input_active <= LIVE_INPUT_ACTIVE; // [R12]
      live.calib_busy <= SYNTH_CALIB_BUSY; // [R13]
    end
  end

  // an event is a live bit standing in its bad state
  wire [NFLAG-1:0] ev;
  assign ev[B_SYNTH] = ~live.synth_locked; // [R3]
  assign ev[B_VCXO] = ~live.vcxo_locked; // [R4] [R11]
  assign ev[B_REF] = ~live.ref_present; // [R7]
  assign ev[B_HOLD] = ~live.not_holdover; // [R8]
  assign ev[B_IN1] = ~live.input_active[1]; // [R6] [R12]
  assign ev[B_IN0] = ~live.input_active[0]; // [R6] [R12]

  wire wr_en = wr.valid && hit(wr.addr, OFF_IRQ_EN);
  wire wr_sticky = wr.valid && hit(wr.addr, OFF_STICKY);
  // only ones clear; zeros in the written byte leave flags alone
  wire [NFLAG-1:0] clr = wr_sticky ? wr.data[NFLAG-1:0] : '0; // [R5] [R20]

  // writes to live and calibration registers fall through untouched
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      irq_en <= IRQ_EN_RST; // [R1] [R15] [R16]
    end else if (wr_en) begin
      irq_en <= wr.data[NFLAG-1:0]; // [R14] [R15] [R16]
    end
  end

  sticky_bank u_sticky (
    .clk(REF_CLK),
    .nrst(NRST),
    .set(ev),
    .clr(clr),
    .seen(seen)
  );

  wire irq_pending = |(seen & irq_en); // [R1] [R2] [R19]

  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      IRQ_OUT_LOW <= IRQ_IDLE;
    end else begin
      IRQ_OUT_LOW <= ~irq_pending; // [R2] [R19]
    end
  end

  // sticky bits read 0 when an event has been seen
  wire [7:0] rd_en = {2'b00, irq_en};
  wire [7:0] rd_sticky = {2'b00, ~seen}; // [R3] [R4] [R6] [R7] [R8]
  wire [7:0] rd_live = {1'b0, live.input_select, live.synth_locked,
                        live.vcxo_locked, live.ref_present,
                        live.not_holdover, live.input_active};
  wire [7:0] rd_calib = {5'b00000, live.calib_busy, 2'b00};
  wire [7:0] rd_data = hit(rd_addr, OFF_IRQ_EN) ? rd_en :
                       hit(rd_addr, OFF_STICKY) ? rd_sticky :
                       hit(rd_addr, OFF_LIVE) ? rd_live :
                       hit(rd_addr, OFF_CALIB) ? rd_calib : RD_UNMAPPED;

  spi_port u_spi (
    .clk(REF_CLK),
    .nrst(NRST),
    .sclk(SCLK),
    .sdi(SDI),
    .cs_n(CS_N),
    .sdo(SDO),
    .sdo_oe(SDO_OE),
    .wr(wr),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!NRST);

  property p_en_reset;
    @(posedge REF_CLK) disable iff (1'b0)
      !NRST |=> irq_en == IRQ_EN_RST && IRQ_OUT_LOW;
  endproperty
  a_en_reset: assert property (p_en_reset) // [R1] [R15] [R16]
    else $error("enable or irq not idle after reset");

  property p_masked_quiet;
    (seen & irq_en) == '0 |=> IRQ_OUT_LOW;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) // [R1] [R19]
    else $error("irq low with no enabled sticky flag");

  property p_irq_fires;
    (seen & irq_en) != '0 |=> !IRQ_OUT_LOW;
  endproperty
  a_irq_fires: assert property (p_irq_fires) // [R2] [R19]
    else $error("enabled sticky flag did not pull irq low");

  property p_irq_from_pin;
    !LIVE_SYNTH_LOCKED && irq_en[B_SYNTH] && !wr.valid
      ##1 irq_en[B_SYNTH] [*2] |=> !IRQ_OUT_LOW;
  endproperty
  a_irq_from_pin: assert property (p_irq_from_pin) // [R2] [R10]
    else $error("synthesizer unlock did not reach irq in three cycles");

  property p_irq_holds;
    // a write lands one cycle before irq follows it, so look one back
    !IRQ_OUT_LOW && !$past(wr.valid) |=> !IRQ_OUT_LOW;
  endproperty
  a_irq_holds: assert property (p_irq_holds) // [R19]
    else $error("irq released without a register write");

  genvar g;
  generate
    for (g = 0; g < NFLAG; g++) begin : g_chk
      property p_latch;
        ev[g] |=> seen[g] [*1] ##0 rd_sticky[g] == 1'b0;
      endproperty
      a_latch: assert property (p_latch) // [R3] [R4] [R6] [R7] [R8] [R20]
        else $error("sticky flag missed an event");

      property p_clear;
        clr[g] && !ev[g] |=> !seen[g];
      endproperty
      a_clear: assert property (p_clear) // [R5] [R6] [R7] [R8]
        else $error("write one did not clear sticky flag");

      property p_keep;
        seen[g] && !clr[g] |=> seen[g];
      endproperty
      a_keep: assert property (p_keep) // [R20]
        else $error("sticky flag dropped without a clear");

      property p_no_spurious;
        !seen[g] && !ev[g] |=> !seen[g];
      endproperty
      a_no_spurious: assert property (p_no_spurious) // [R3] [R4] [R20]
        else $error("sticky flag set without an event");
    end
  endgenerate

  property p_enable_write;
    wr_en |=> irq_en == $past(wr.data[NFLAG-1:0]);
  endproperty
  a_enable_write: assert property (p_enable_write) // [R14] [R15] [R16]
    else $error("enable register did not take the written value");

  property p_enable_steady;
    !wr_en |=> $stable(irq_en);
  endproperty
  a_enable_steady: assert property (p_enable_steady) // [R1]
    else $error("enable register changed without a write");

  property p_live_read;
    hit(rd_addr, OFF_LIVE) |-> rd_data[B_SEL] == live.input_select
      && rd_data[B_SYNTH] == live.synth_locked
      && rd_data[B_VCXO] == live.vcxo_locked
      && rd_data[B_REF] == live.ref_present
      && rd_data[B_HOLD] == live.not_holdover
      && rd_data[B_IN1:B_IN0] == live.input_active;
  endproperty
  a_live_read: assert property (p_live_read) // [R9] [R10] [R11] [R12] [R17]
    else $error("live register read does not match live conditions");

  property p_live_track;
    ##1 live.synth_locked == $past(LIVE_SYNTH_LOCKED)
      && live.input_select == $past(LIVE_INPUT_SELECT)
      && live.calib_busy == $past(SYNTH_CALIB_BUSY);
  endproperty
  a_live_track: assert property (p_live_track) // [R9] [R10] [R13]
    else $error("live sample lags its pin by more than one cycle");

  property p_calib_read;
    hit(rd_addr, OFF_CALIB) |-> rd_data == {5'b00000, live.calib_busy, 2'b00};
  endproperty
  a_calib_read: assert property (p_calib_read) // [R13]
    else $error("calibration register read is wrong");

  property p_ro_live;
    wr.valid && hit(wr.addr, OFF_LIVE) |-> clr == '0 && !wr_en;
  endproperty
  a_ro_live: assert property (p_ro_live) // [R10]
    else $error("write to live register had an effect");

  property p_ro_calib;
    wr.valid && hit(wr.addr, OFF_CALIB) |-> clr == '0 && !wr_en;
  endproperty
  a_ro_calib: assert property (p_ro_calib) // [R13]
    else $error("write to calibration register had an effect");

  // reserved enable bits read zero so software can mask blindly
  property p_en_read;
    hit(rd_addr, OFF_IRQ_EN) |-> rd_data[7:6] == 2'b00
      && rd_data[NFLAG-1:0] == irq_en;
  endproperty
  a_en_read: assert property (p_en_read) // [R14] [R15] [R16]
    else $error("enable register read is wrong");

  property p_sticky_read;
    hit(rd_addr, OFF_STICKY) |-> rd_data[7:6] == 2'b00
      && rd_data[B_SYNTH] != seen[B_SYNTH]
      && rd_data[B_VCXO] != seen[B_VCXO];
  endproperty
  a_sticky_read: assert property (p_sticky_read) // [R3] [R4]
    else $error("sticky lock flags read with the wrong polarity");

  property p_sticky_read_in;
    hit(rd_addr, OFF_STICKY) |-> rd_data[B_REF] != seen[B_REF]
      && rd_data[B_HOLD] != seen[B_HOLD]
      && rd_data[B_IN1:B_IN0] == ~seen[B_IN1:B_IN0];
  endproperty
  a_sticky_read_in: assert property (p_sticky_read_in) // [R6] [R7] [R8]
    else $error("sticky input flags read with the wrong polarity");

  property p_unmapped_read;
    !hit(rd_addr, OFF_IRQ_EN) && !hit(rd_addr, OFF_STICKY)
      && !hit(rd_addr, OFF_LIVE) && !hit(rd_addr, OFF_CALIB)
      |-> rd_data == RD_UNMAPPED;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) // [R10]
    else $error("unmapped address did not read zero");

  // pin to flag takes two cycles: one for the live sample, one to latch
  property p_synth_flag;
    !LIVE_SYNTH_LOCKED |-> ##2 seen[B_SYNTH];
  endproperty
  a_synth_flag: assert property (p_synth_flag) // [R3] [R10]
    else $error("synthesizer unlock was not latched");

  property p_vcxo_flag;
    !LIVE_VCXO_LOCKED |-> ##2 seen[B_VCXO];
  endproperty
  a_vcxo_flag: assert property (p_vcxo_flag) // [R4] [R11]
    else $error("vcxo unlock was not latched");

  property p_ref_flag;
    !LIVE_REF_PRESENT |-> ##2 seen[B_REF];
  endproperty
  a_ref_flag: assert property (p_ref_flag) // [R7] [R17]
    else $error("reference loss was not latched");

  property p_hold_flag;
    !LIVE_NOT_HOLDOVER |-> ##2 seen[B_HOLD];
  endproperty
  a_hold_flag: assert property (p_hold_flag) // [R8] [R18]
    else $error("holdover entry was not latched");

  property p_in0_flag;
    !LIVE_INPUT_ACTIVE[0] |-> ##2 seen[B_IN0];
  endproperty
  a_in0_flag: assert property (p_in0_flag) // [R6] [R12]
    else $error("input 0 loss of signal was not latched");

  property p_in1_flag;
    !LIVE_INPUT_ACTIVE[1] |-> ##2 seen[B_IN1];
  endproperty
  a_in1_flag: assert property (p_in1_flag) // [R6] [R12]
    else $error("input 1 loss of signal was not latched");

  property p_zero_write;
    wr_sticky && wr.data[NFLAG-1:0] == '0
      |=> seen == ($past(seen) | $past(ev));
  endproperty
  a_zero_write: assert property (p_zero_write) // [R20]
    else $error("writing zero to sticky register changed a flag");

  property p_reset_idle;
    @(posedge REF_CLK) disable iff (1'b0)
      !NRST |=> seen == SEEN_RST && !SDO_OE && !SDO;
  endproperty
  a_reset_idle: assert property (p_reset_idle) // [R3] [R4]
    else $error("sticky flags or serial output not idle after reset");

  property p_live_rest;
    ##1 live.vcxo_locked == $past(LIVE_VCXO_LOCKED)
      && live.ref_present == $past(LIVE_REF_PRESENT)
      && live.not_holdover == $past(LIVE_NOT_HOLDOVER)
      && live.input_active == $past(LIVE_INPUT_ACTIVE);
  endproperty
  a_live_rest: assert property (p_live_rest) // [R11] [R12] [R17] [R18]
    else $error("live condition sample lags its pin");

  c_irq: cover property (irq_en != '0 ##1 !IRQ_OUT_LOW);
  c_clear_release: cover property (!IRQ_OUT_LOW ##1 wr_sticky ##[1:3]
    IRQ_OUT_LOW);
  c_set_and_clear: cover property (|(clr & ev));
  c_live_read: cover property (SDO_OE && hit(rd_addr, OFF_LIVE));
  c_pin_to_irq: cover property (!LIVE_SYNTH_LOCKED ##3 !IRQ_OUT_LOW);

endmodule

// ---- verif/spi_host.sv ----
`timescale 1ns/1ps
module spi_host (
  input wire logic clk, // register clock
  output logic sclk, // serial clock, idle low
  output logic sdi, // serial data to the device
  output logic cs_n, // select, active low
  input wire logic sdo, // serial data from the device
  input wire logic sdo_oe // high while the device drives sdo
);
  initial begin
    sclk = 1'b0;
    sdi = 1'b0;
    cs_n = 1'b1;
  end

  // four clocks per half period leaves margin over the two clock minimum
  task automatic half();
    repeat (4) @(posedge clk);
    #1;
  endtask

  // fewer than 16 bits cuts the frame short, which must write nothing
  task automatic xfer(input logic [15:0] word, input int nbits,
                      output logic [7:0] rdata);
    rdata = 8'h00;
    @(posedge clk);
    #1;
    cs_n = 1'b0;
    for (int i = 15; i >= 16 - nbits; i--) begin
      sdi = word[i];
      half();
      if (i < 8)
        rdata[i] = sdo_oe ? sdo : 1'bx;
      sclk = 1'b1;
      half();
      sclk = 1'b0;
    end
    half();
    cs_n = 1'b1;
    // released line must not keep showing the last bit
    sdi = ~sdi;
    repeat (3) @(posedge clk);
    #1;
  endtask
endmodule

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import clk_status_pkg::*;

  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic sclk;
  logic sdi;
  logic cs_n;
  logic sdo;
  logic sdo_oe;
  logic irq_n;
  // same bit order as the live register: select, synth, vcxo, ref, hold, act
  logic [6:0] live = 7'h3f;
  logic calib = 1'b0;
  logic [7:0] rd;
  logic [7:0] m;
  int n_errors = 0;
  int check_count = 0;

  always #12.5 ref_clk = ~ref_clk;

  spi_host i_spi_host (.clk(ref_clk), .sclk(sclk), .sdi(sdi), .cs_n(cs_n),
    .sdo(sdo), .sdo_oe(sdo_oe));

  clock_status_interrupt_logic i_clock_status_interrupt_logic (
    .REF_CLK(ref_clk), .NRST(nrst), .SCLK(sclk), .SDI(sdi), .CS_N(cs_n),
    .SDO(sdo), .SDO_OE(sdo_oe), .IRQ_OUT_LOW(irq_n),
    .LIVE_INPUT_SELECT(live[6]), .LIVE_SYNTH_LOCKED(live[5]),
    .LIVE_VCXO_LOCKED(live[4]), .LIVE_REF_PRESENT(live[3]),
    .LIVE_NOT_HOLDOVER(live[2]), .LIVE_INPUT_ACTIVE(live[1:0]),
    .SYNTH_CALIB_BUSY(calib));

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    i_spi_host.xfer({1'b0, a, d}, 16, rd);
  endtask

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
    i_spi_host.xfer({1'b1, a, 8'h00}, 16, rd);
    check($sformatf("register %h", a), rd, exp);
  endtask

  task automatic irq_chk(input logic e);
    repeat (4) @(posedge ref_clk);
    #1;
    check("interrupt", {7'h00, irq_n}, {7'h00, e});
  endtask

  // one cycle of bad condition is enough to latch a flag
  task automatic pulse(input int i);
    @(posedge ref_clk);
    #1;
    live[i] = 1'b0;
    @(posedge ref_clk);
    #1;
    live[i] = 1'b1;
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge ref_clk);
    #1;
    nrst = 1'b1;
    irq_chk(1'b1);
    rd_chk(OFF_IRQ_EN, 8'h00);
    rd_chk(OFF_STICKY, 8'h3f);
    for (int b = 0; b < 7; b++) begin
      live = 7'h3f ^ (7'h01 << b);
      calib = ~b[0];
      rd_chk(OFF_LIVE, {1'b0, live});
      rd_chk(OFF_CALIB, {5'h00, calib, 2'b00});
    end
    live = 7'h3f;
    wr(OFF_STICKY, 8'hff);
    wr(OFF_LIVE, 8'h00);
    rd_chk(OFF_LIVE, 8'h3f);
    rd_chk(7'h7f, 8'h00);
    i_spi_host.xfer({1'b0, OFF_IRQ_EN, 8'h3f}, 12, rd);
    rd_chk(OFF_IRQ_EN, 8'h00);
    for (int i = 0; i < 6; i++) begin
      m = 8'h01 << i;
      pulse(i);
      irq_chk(1'b1);
      rd_chk(OFF_STICKY, 8'h3f ^ m);
      wr(OFF_STICKY, 8'h00);
      wr(OFF_IRQ_EN, m);
      rd_chk(OFF_IRQ_EN, m);
      irq_chk(1'b0);
      rd_chk(OFF_STICKY, 8'h3f ^ m);
      wr(OFF_IRQ_EN, 8'h00);
      irq_chk(1'b1);
      wr(OFF_IRQ_EN, m);
      wr(OFF_STICKY, m);
      irq_chk(1'b1);
      rd_chk(OFF_STICKY, 8'h3f);
    end
    wr(OFF_IRQ_EN, 8'h3f);
    pulse(0);
    pulse(1);
    pulse(5);
    irq_chk(1'b0);
    wr(OFF_STICKY, 8'h01);
    irq_chk(1'b0);
    wr(OFF_STICKY, 8'h22);
    irq_chk(1'b1);
    conclude();
  end

  // failsafe: the whole sequence needs well under a millisecond
  initial begin
    #2000000;
    n_errors++;
    conclude();
  end
endmodule
